// ===== mdsl_pkg.sv
// Purpose: shared constants and types of the multichannel DAC serial loader
// Assumes: mclk at 100 MHz, serial clock from the host on its own domain
// Notes: frame layout, reset code and sequencer figures live here
//
// What this block does
// - Each frame is 24 bits, most significant bit first.
// - Order: 16 code, 4 address, zero, update mode, clock source, zero.
// - First rising serial edge after select low takes the first bit.
// - Full frame writes code into addressed slot and latches control bits.
// - Address field is a plain binary channel number, 0 to 15.
// - Update-mode bit 1 means immediate, 0 means burst.
// - Clock-source bit 0 internal, 1 external; host repeats it each word.
// - Mode and clock pins are ORed with the control bits.
// - Immediate update within 2 periods; burst refresh within 33 periods.
// - After reset every slot holds the zero-volt code.
// - Modes: continuous sequencing, immediate update, burst loading.
// - Sequencer walks all 16 slots, loading and strobing each channel.
// - External clock: sequencer at a quarter rate, internal oscillator off.
// - Immediate: halt on select, finish step on internal clock, update, resume slot.
// - Burst: halt on select, resume at interrupted slot afterwards.

package mdsl_pkg;

	localparam int MDSL_FRAME_BITS = 24;
	localparam int MDSL_CODE_W = 16;
	localparam int MDSL_ADDR_W = 4;
	localparam int MDSL_CHANNELS = 16;
	// Field positions inside the received frame
	localparam int MDSL_CODE_LSB = 8;
	localparam int MDSL_ADDR_LSB = 4;
	localparam int MDSL_ZERO_POS = 3;
	localparam int MDSL_UPD_POS = 2;
	localparam int MDSL_CLK_POS = 1;
	localparam int MDSL_FILL_POS = 0;
	localparam logic [15:0] MDSL_RESET_CODE = 16'h4F2C;
	// Internal sequencer period: 20 us per channel
	localparam int MDSL_INT_STEP_NS = 20000;
	localparam int MDSL_CLK_NS = 10;
	localparam int MDSL_INT_STEP_CYC = MDSL_INT_STEP_NS / MDSL_CLK_NS;
	// External sequencer: one step per four external clocks
	localparam int MDSL_EXT_DIV = 4;
	localparam int MDSL_FIFO_DEPTH = 16;

	typedef struct packed {
		logic [15:0] code;
		logic [3:0] addr;
		logic update_mode_bit;
		logic clock_source_bit;
	} mdsl_word_s;

	typedef struct packed {
		logic valid;
		logic [3:0] channel;
		logic [15:0] code;
	} mdsl_strobe_s;

	typedef enum logic [1:0] {
		MDSL_RUN,
		MDSL_HALT,
		MDSL_IMMEDIATE_MODE_PIN
	} mdsl_seq_e;

endpackage : mdsl_pkg

// ===== mdsl_fifo.sv
// Purpose: word FIFO between serial domain handoff and the sequencer
// Assumes: single clock, flip-flop storage
// Notes: honest full and empty; ready low when full

`timescale 1ns/1ps
`default_nettype none

module mdsl_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("mdsl_fifo depth must be a power of two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} mdsl_fifo_s;

	mdsl_fifo_s st_reg, st_next;
	logic full, empty;

	assign empty = st_reg.wr == st_reg.rd;
	assign full = (st_reg.wr[AW] != st_reg.rd[AW]) &&
		(st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = st_reg.mem[st_reg.rd[AW-1:0]];

	always_comb begin
		st_next = st_reg;
		if (in_valid && !full) begin
			st_next.mem[st_reg.wr[AW-1:0]] = in_data;
			st_next.wr = st_reg.wr + 1'b1;
		end
		if (out_ready && !empty)
			st_next.rd = st_reg.rd + 1'b1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end

endmodule : mdsl_fifo

`default_nettype wire

// ===== mdsl_shifter.sv
// Purpose: serial-clock-domain receiver of 24-bit frames
// Assumes: serial clock stands still outside frames
// Notes: frame handed over by toggle and a stable holding register

`timescale 1ns/1ps
`default_nettype none

module mdsl_shifter
	import mdsl_pkg::*;
(
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdin,
	input wire logic reset_n,
	// Handoff
	output logic [MDSL_FRAME_BITS-1:0] frame_hold,
	output logic frame_toggle
);

	typedef struct packed {
		logic [MDSL_FRAME_BITS-1:0] shift;
		logic [MDSL_FRAME_BITS-1:0] hold;
		logic toggle;
	} mdsl_shift_s;

	mdsl_shift_s st_reg, st_next;
	logic [MDSL_FRAME_BITS-1:0] shifted;
	logic [4:0] count_reg, count_next;

	assign frame_hold = st_reg.hold;
	assign frame_toggle = st_reg.toggle;
	assign shifted = {st_reg.shift[MDSL_FRAME_BITS-2:0], sdin};

	always_comb begin
		st_next = st_reg;
		st_next.shift = shifted;
		count_next = count_reg + 5'h01;
		if (count_reg == 5'(MDSL_FRAME_BITS - 1)) begin
			count_next = '0;
			st_next.hold = shifted;
			st_next.toggle = !st_reg.toggle;
		end
	end

	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else if (!cs_n) begin
			st_reg <= st_next;
		end
	end

	// Select high clears the count at once: sclk idles after a cut frame
	always_ff @(posedge sclk or negedge reset_n or posedge cs_n) begin
		if (!reset_n)
			count_reg <= '0;
		else if (cs_n)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

endmodule : mdsl_shifter

`default_nettype wire

// ===== mdsl_loader.sv
// Purpose: serial loader, SRAM and sequencer of a 16-channel DAC
// Assumes: host respects whole 24-bit frames; ext clock is a pin input
// Notes: sequencer strobes one channel per step on mclk

`timescale 1ns/1ps
`default_nettype none

module mdsl_loader
	import mdsl_pkg::*;
#(
	parameter int INT_STEP_CYC = MDSL_INT_STEP_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdin,
	// Mode pins
	input wire logic immediate_mode_pin,
	input wire logic ext_clock_select_pin,
	input wire logic external_sequencer_clock,
	// Channel strobe to the converter
	output logic dac_load,
	output logic [3:0] dac_channel,
	output logic [15:0] dac_code,
	// Status
	output logic immediate_active,
	output logic external_clock_active,
	output logic internal_osc_enable,
	output logic reset_busy,
	output logic frame_error
);

	initial begin
		if (INT_STEP_CYC < 2)
			$error("mdsl_loader step count too small");
	end

	localparam int WORD_W = MDSL_CODE_W + MDSL_ADDR_W + 2;

	function automatic mdsl_word_s mdsl_decode(
		input logic [MDSL_FRAME_BITS-1:0] f);
		mdsl_word_s w;
		w.code = f[MDSL_CODE_LSB +: MDSL_CODE_W];
		w.addr = f[MDSL_ADDR_LSB +: MDSL_ADDR_W];
		w.update_mode_bit = f[MDSL_UPD_POS];
		w.clock_source_bit = f[MDSL_CLK_POS];
		return w;
	endfunction : mdsl_decode

	////////////////////////////////////////////////////////////////////////
	// Serial domain

	logic [MDSL_FRAME_BITS-1:0] frame_hold;
	logic frame_toggle;

	mdsl_shifter u_shifter (
		.sclk(sclk),
		.cs_n(cs_n),
		.sdin(sdin),
		.reset_n(reset_n),
		.frame_hold(frame_hold),
		.frame_toggle(frame_toggle)
	);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [2:0] tog_sync;
		logic [2:0] cs_sync;
		logic [2:0] imm_sync;
		logic [2:0] sel_sync;
		logic [2:0] eck_sync;
		logic upd_bit;
		logic clk_bit;
		logic [MDSL_CHANNELS-1:0][15:0] sram;
		mdsl_seq_e seq;
		logic [3:0] slot;
		logic [15:0] tick_cnt;
		logic [1:0] ext_cnt;
		logic step_busy;
		logic [4:0] reset_left;
		logic pend;
		logic [3:0] pend_ch;
		logic ferr;
		mdsl_strobe_s strobe;
		logic imm_o;
		logic ext_o;
		logic eck_lvl;
		logic busy_o;
		logic osc_o;
	} mdsl_state_s;

	mdsl_state_s st_reg, st_next;

	logic tog_seen, cs_low, cs_rise, imm_pin, sel_pin, eck_rise;
	logic use_imm, use_ext, tick, fifo_ready, fifo_valid, fifo_pop;
	logic [WORD_W-1:0] fifo_data;
	mdsl_word_s word_in, word_out;

	// Levels need second and third stages to agree; a toggle is new while they differ
	assign tog_seen = st_reg.tog_sync[1] == st_reg.tog_sync[2];
	assign cs_low = !st_reg.cs_sync[1] && !st_reg.cs_sync[2];
	assign cs_rise = st_reg.cs_sync[1] && st_reg.cs_sync[2] &&
		st_reg.seq == MDSL_HALT;
	assign imm_pin = st_reg.imm_sync[1] && st_reg.imm_sync[2];
	assign sel_pin = st_reg.sel_sync[1] && st_reg.sel_sync[2];
	// One pulse per settled low-to-high change, not a level
	assign eck_rise = st_reg.eck_sync[1] && st_reg.eck_sync[2] &&
		!st_reg.eck_lvl;

	// Pin or control bit at 1 wins
	assign use_imm = st_reg.upd_bit || imm_pin;
	// Reset sequence always runs from the internal clock
	assign use_ext = (st_reg.clk_bit || sel_pin) &&
		st_reg.reset_left == '0;

	////////////////////////////////////////////////////////////////////////
	// Frame FIFO: a word arriving while full is dropped; ready does not stall the link

	assign word_in = mdsl_decode(frame_hold);
	assign fifo_pop = fifo_valid && st_reg.reset_left == '0;
	assign word_out = mdsl_word_s'(fifo_data);

	mdsl_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(MDSL_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.in_valid(!tog_seen),
		.in_ready(fifo_ready),
		.in_data(word_in),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer tick: internal divider or a quarter of the external clock

	always_comb begin
		tick = 1'b0;
		if (use_ext)
			tick = eck_rise && st_reg.ext_cnt == 2'(MDSL_EXT_DIV - 1);
		else
			tick = st_reg.tick_cnt == 16'(INT_STEP_CYC - 1);
	end

	always_comb begin
		st_next = st_reg;
		st_next.tog_sync = {st_reg.tog_sync[1:0], frame_toggle};
		st_next.cs_sync = {st_reg.cs_sync[1:0], cs_n};
		st_next.imm_sync = {st_reg.imm_sync[1:0], immediate_mode_pin};
		st_next.sel_sync = {st_reg.sel_sync[1:0], ext_clock_select_pin};
		st_next.eck_sync = {st_reg.eck_sync[1:0],
			external_sequencer_clock};
		st_next.strobe.valid = 1'b0;
		st_next.imm_o = use_imm;
		st_next.ext_o = use_ext;
		st_next.osc_o = !use_ext;
		if (st_reg.eck_sync[1] == st_reg.eck_sync[2])
			st_next.eck_lvl = st_reg.eck_sync[2];

		// Internal oscillator stops while the external clock is chosen
		if (use_ext)
			st_next.tick_cnt = '0;
		else if (tick)
			st_next.tick_cnt = '0;
		else
			st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
		if (use_ext && eck_rise)
			st_next.ext_cnt = st_reg.ext_cnt + 2'h1;

		// Word lost when the FIFO is full; reported, not stored
		if (!tog_seen && !fifo_ready)
			st_next.ferr = 1'b1;

		// Pop one stored frame into SRAM
		if (fifo_pop) begin
			st_next.sram[word_out.addr] = word_out.code;
			st_next.upd_bit = word_out.update_mode_bit;
			st_next.clk_bit = word_out.clock_source_bit;
			st_next.pend = 1'b1;
			st_next.pend_ch = word_out.addr;
		end

		unique case (st_reg.seq)
			// Continuous walk of all slots
			MDSL_RUN: begin
				if (tick) begin
					st_next.strobe.valid = 1'b1;
					st_next.strobe.channel = st_reg.slot;
					st_next.strobe.code = st_reg.sram[st_reg.slot];
					st_next.slot = st_reg.slot + 4'h1;
					if (st_reg.reset_left != '0)
						st_next.reset_left = st_reg.reset_left - 5'h01;
				end
				// With the internal clock the step in progress finishes before halting
				if (cs_low && st_reg.reset_left == '0 && (tick ||
					!st_reg.step_busy)) begin
					st_next.seq = MDSL_HALT;
					st_next.pend = 1'b0;
				end
			end
			// Select low: no channel refreshed
			MDSL_HALT: begin
				if (cs_rise && !fifo_valid && tog_seen) begin
					if (use_imm && st_reg.pend)
						st_next.seq = MDSL_IMMEDIATE_MODE_PIN;
					else
						st_next.seq = MDSL_RUN;
				end
			end
			// One extra step for the addressed channel
			MDSL_IMMEDIATE_MODE_PIN: begin
				if (tick) begin
					st_next.strobe.valid = 1'b1;
					st_next.strobe.channel = st_reg.pend_ch;
					st_next.strobe.code = st_reg.sram[st_reg.pend_ch];
					st_next.pend = 1'b0;
					st_next.seq = MDSL_RUN;
				end
			end
			default: st_next.seq = MDSL_RUN;
		endcase
		st_next.step_busy = st_reg.seq == MDSL_RUN &&
			(st_reg.step_busy ? !tick : st_reg.tick_cnt != '0);
		st_next.busy_o = st_next.reset_left != '0;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.seq <= MDSL_RUN;
			st_reg.sram <= {MDSL_CHANNELS{MDSL_RESET_CODE}};
			st_reg.reset_left <= 5'(MDSL_CHANNELS);
			st_reg.cs_sync <= 3'h7;
			st_reg.tog_sync <= 3'h0;
			st_reg.busy_o <= 1'b1;
			st_reg.osc_o <= 1'b1;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops

	assign dac_load = st_reg.strobe.valid;
	assign dac_channel = st_reg.strobe.channel;
	assign dac_code = st_reg.strobe.code;
	assign immediate_active = st_reg.imm_o;
	assign external_clock_active = st_reg.ext_o;
	assign internal_osc_enable = st_reg.osc_o;
	assign reset_busy = st_reg.busy_o;
	assign frame_error = st_reg.ferr;

endmodule : mdsl_loader

`default_nettype wire

// ===== mdsl_loader_asserts.sv
// Purpose: port-level checks of the DAC serial loader
// Assumes: short sequencer step in simulation
// Notes: bound to mdsl_loader after the module
`timescale 1ns/1ps
`default_nettype none
module mdsl_loader_asserts
	import mdsl_pkg::*;
#(
	parameter int INT_STEP_CYC = MDSL_INT_STEP_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Link and pins
	input wire logic cs_n,
	input wire logic immediate_mode_pin,
	input wire logic ext_clock_select_pin,
	// Outputs
	input wire logic dac_load,
	input wire logic [3:0] dac_channel,
	input wire logic [15:0] dac_code,
	input wire logic immediate_active,
	input wire logic external_clock_active,
	input wire logic internal_osc_enable,
	input wire logic reset_busy
);
	logic [7:0] cs_lo_reg;
	logic [3:0] prev_ch_reg;
	logic seen_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cs_lo_reg <= 8'h00;
			prev_ch_reg <= 4'h0;
			seen_reg <= 1'b0;
		end else begin
			cs_lo_reg <= cs_n ? 8'h00 : cs_lo_reg + {7'h00, cs_lo_reg != 8'hFF};
			if (dac_load && reset_busy) begin
				prev_ch_reg <= dac_channel;
				seen_reg <= 1'b1;
			end
		end
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence imm_release_s;
		$rose(cs_n) && immediate_active && !reset_busy && clk_en;
	endsequence
	sequence strobe_s;
		dac_load;
	endsequence
	////////////////////////////////////////////////////////////////////////
	osc_inverse_a: assert property (internal_osc_enable == !external_clock_active)
		else $error("oscillator enable not inverse of clock select");
	load_pulse_a: assert property (strobe_s |=> !dac_load)
		else $error("strobe longer than one cycle");
	reset_code_a: assert property (dac_load && reset_busy |-> dac_code == MDSL_RESET_CODE)
		else $error("reset refresh with wrong code");
	reset_order_a: assert property (dac_load && reset_busy && seen_reg |-> dac_channel == prev_ch_reg + 4'h1)
		else $error("reset refresh out of order");
	reset_done_a: assert property ($rose(reset_n) |-> ##[1:400] !reset_busy)
		else $error("reset refresh too long");
	// Allows the step in progress plus the select synchroniser
	halt_select_a: assert property (cs_lo_reg >= 8'(4 * INT_STEP_CYC) && !reset_busy |-> !dac_load)
		else $error("strobe while select held low");
	imm_update_a: assert property (imm_release_s |-> ##[1:40] strobe_s)
		else $error("immediate update late");
	imm_pin_a: assert property ((immediate_mode_pin && clk_en) [*5] |-> immediate_active)
		else $error("mode pin not obeyed");
	ext_pin_a: assert property ((ext_clock_select_pin && clk_en && !reset_busy) [*5] |-> external_clock_active)
		else $error("clock pin not obeyed");
endmodule : mdsl_loader_asserts
bind mdsl_loader mdsl_loader_asserts #(.INT_STEP_CYC(INT_STEP_CYC)) chk_u (
	.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n),
	.immediate_mode_pin(immediate_mode_pin),
	.ext_clock_select_pin(ext_clock_select_pin), .dac_load(dac_load),
	.dac_channel(dac_channel), .dac_code(dac_code),
	.immediate_active(immediate_active),
	.external_clock_active(external_clock_active),
	.internal_osc_enable(internal_osc_enable), .reset_busy(reset_busy));
`default_nettype wire

// ===== mdsl_host_model.sv
// Purpose: serial master feeding the DAC loader
// Assumes: serial clock period 125 ns, idle low outside frames
// Notes: data line inverts once released, never holds its last bit
`timescale 1ns/1ps
`default_nettype none
module mdsl_host_model (
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic sdin
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdin = 1'b1;
	end
	// Sends the top nbits of v; a short count makes a partial frame
	task automatic send(input logic [47:0] v, input int nbits);
		cs_n = 1'b0;
		#40;
		for (int b = 47; b > 47 - nbits; b--) begin
			sdin = v[b];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		sdin = ~sdin;
	endtask : send
endmodule : mdsl_host_model
`default_nettype wire

// ===== multichannel_dac_serial_loader_tb_top.sv
// Purpose: self-checking bench of the DAC serial loader
// Assumes: host model drives the serial link
// Notes: short sequencer step keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module multichannel_dac_serial_loader_tb_top
	import mdsl_pkg::*;
;
	logic mclk, reset_n, clk_en, immediate_mode_pin, ext_clock_select_pin;
	logic sclk, cs_n, sdin, dac_load, immediate_active, reset_busy;
	logic external_clock_active, internal_osc_enable, frame_error;
	logic [1:0] div;
	logic [3:0] dac_channel;
	logic [15:0] dac_code, got;
	int miscompares, n_tests;
	mdsl_host_model host_u (.sclk(sclk), .cs_n(cs_n), .sdin(sdin));
	mdsl_loader #(.INT_STEP_CYC(8)) dut_u (.mclk(mclk), .reset_n(reset_n),
		.clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .sdin(sdin),
		.immediate_mode_pin(immediate_mode_pin),
		.ext_clock_select_pin(ext_clock_select_pin),
		.external_sequencer_clock(div[1]), .dac_load(dac_load),
		.dac_channel(dac_channel), .dac_code(dac_code),
		.immediate_active(immediate_active),
		.external_clock_active(external_clock_active),
		.internal_osc_enable(internal_osc_enable), .reset_busy(reset_busy),
		.frame_error(frame_error));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// External clock at a quarter of mclk
	always @(posedge mclk) div <= div + 2'h1;
	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : check
	task tally_and_finish;
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	function automatic logic [23:0] fr(logic [15:0] c, logic [3:0] a,
		logic u, logic k);
		return {c, a, 1'b0, u, k, 1'b0};
	endfunction : fr
	// Leaves code unknown when no strobe comes, so the compare fails
	task automatic strobe(input logic [3:0] ch, output logic [15:0] code);
		code = 16'hXXXX;
		for (int i = 0; i < 400; i++) begin
			@(posedge mclk);
			#1;
			if (dac_load === 1'b1 && dac_channel === ch) begin
				code = dac_code;
				break;
			end
		end
	endtask : strobe
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		check(reset_busy, 1'b1, "busy in reset");
		check(internal_osc_enable, 1'b1, "osc in reset");
		@(posedge mclk);
		reset_n <= 1'b1;
		strobe(4'h5, got);
		check(got, MDSL_RESET_CODE, "reset code");
		for (int i = 0; i < 400 && reset_busy !== 1'b0; i++) begin
			@(posedge mclk);
			#1;
		end
		check(reset_busy, 1'b0, "reset done");
	endtask : t_reset
	task automatic t_imm(input logic [3:0] ch, input logic [15:0] c);
		host_u.send({fr(c, ch, 1'b1, 1'b0), 24'h000000}, 24);
		strobe(ch, got);
		check(got, c, "immediate code");
		check(immediate_active, 1'b1, "immediate mode");
	endtask : t_imm
	task t_burst;
		host_u.send({fr(16'hA5A5, 4'h3, 1'b0, 1'b0),
			fr(16'h5A5A, 4'hF, 1'b0, 1'b0)}, 48);
		check(immediate_active, 1'b0, "burst mode");
		strobe(4'h3, got);
		check(got, 16'hA5A5, "burst first");
		strobe(4'hF, got);
		check(got, 16'h5A5A, "burst second");
	endtask : t_burst
	// Update bit falls inside the 23 bits sent
	task t_partial;
		host_u.send({fr(16'h1234, 4'h7, 1'b1, 1'b0), 24'h000000}, 23);
		check(immediate_active, 1'b0, "partial control");
		strobe(4'h7, got);
		check(got, MDSL_RESET_CODE, "partial data");
	endtask : t_partial
	task t_clock;
		host_u.send({fr(16'h0001, 4'h1, 1'b0, 1'b1), 24'h000000}, 24);
		check(external_clock_active, 1'b1, "ext clock");
		check(internal_osc_enable, 1'b0, "osc off");
		strobe(4'h1, got);
		check(got, 16'h0001, "ext step");
		host_u.send({fr(16'h0002, 4'h2, 1'b0, 1'b0), 24'h000000}, 24);
		check(external_clock_active, 1'b0, "int clock");
		@(posedge mclk);
		ext_clock_select_pin <= 1'b1;
		immediate_mode_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(external_clock_active, 1'b1, "clock pin");
		check(immediate_active, 1'b1, "mode pin");
		check(frame_error, 1'b0, "no drop");
	endtask : t_clock
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		div = 2'h0;
		immediate_mode_pin = 1'b0;
		ext_clock_select_pin = 1'b0;
		miscompares = 0;
		n_tests = 0;
		repeat (16) @(posedge mclk);
		#1;
		t_reset;
		t_imm(4'h0, 16'h0000);
		t_imm(4'hC, 16'hFFFF);
		t_burst;
		t_partial;
		t_clock;
		tally_and_finish;
	end
	initial begin
		#500us;
		miscompares++;
		tally_and_finish;
	end
endmodule : multichannel_dac_serial_loader_tb_top
`default_nettype wire
